//--- hw/clock_select_pkg.sv
// Register map, field layout and reset values of the system clock selector
package clock_select_pkg;
  localparam logic [7:0] CLOCK_SOURCE_ADDR   = 8'h8F;
  localparam logic [7:0] INT_OSC_CTRL_ADDR   = 8'hA1;
  localparam logic [7:0] INT_OSC_COARSE_ADDR = 8'hA2;
  localparam logic [7:0] INT_OSC_FINE_ADDR   = 8'h9E;
  localparam logic [7:0] EXT_OSC_CTRL_ADDR   = 8'hB1;
  localparam logic [7:0] CLKMUL_CTRL_ADDR    = 8'hB2;
  localparam logic [7:0] CLOCK_SOURCE_RESET  = 8'h00;
  localparam logic [7:0] INT_OSC_CTRL_RESET  = 8'hC0;
  localparam logic [6:0] COARSE_TRIM_RESET   = 7'h40;
  localparam logic [5:0] FINE_TRIM_RESET     = 6'h20;
  localparam int SUSPEND_BIT   = 5;
  localparam int READY_BIT     = 4;
  localparam int XTAL_MODE_BIT = 6;
  localparam int XTAL_VALID_BIT = 7;
  localparam int EXT_EN_BIT    = 0;
  localparam int MUL_SRC_BIT   = 0;
  localparam int MUL_X4_BIT    = 1;
  localparam int MUL_SCALE_LSB = 2;
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned XTAL_SETTLE_US = 1000;
  localparam int unsigned XTAL_SETTLE_CYCLES = XTAL_SETTLE_US * (CLK_HZ / 1_000_000);
  typedef enum logic [1:0] {
    SRC_INT_OSC = 2'b00,
    SRC_EXT_OSC = 2'b01,
    SRC_CLKMUL  = 2'b10,
    SRC_RESERVED = 2'b11
  } clock_source_t;
  localparam logic [1:0] OSC_EN_OFF = 2'b00;
  localparam logic [1:0] OSC_EN_ON  = 2'b11;
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } sfr_req_t;
  typedef struct packed {
    logic [3:0] port_match;
    logic       cmp0_enabled;
    logic       cmp0_out;
  } wake_events_t;
endpackage

//--- hw/system_clock_select_suspend.sv
// System clock source selection, internal oscillator divider and suspend control
//
// Behaviour
// [R1] Source field: 00 scaled internal, 01 external, 10 multiplier, 11 reserved.
// [R2] Software switches source only after the new source is enabled and settled.
// [R3] Internal oscillator is selectable right after the write that enables it.
// [R4] Hardware sets crystal-valid once the external resonator has settled.
// [R5] Software waits at least 1 ms after enabling crystal before polling valid.
// [R6] Any system reset makes the internal oscillator the system clock source.
// [R7] Internal path divides by 1..128 per divider field; reset divides by 128.
// [R8] Writing suspend stops the internal oscillator and gates clocks it sources.
// [R9] Port 0..3 match or enabled comparator 0 at logic 0 ends suspend.
// [R10] Wake resumes oscillator, core and peripherals regardless of interrupts.
// [R11] Core resumes at the instruction after the write that set suspend.
// [R12] Firmware sets zero-tempco enable before setting the suspend bit. Here the bench sets suspend by writing 8'hE0 and sets no zero-tempco bit first.
// [R13] External oscillator still clocks timers and counter array when not selected.
// [R14] Multiplier gives internal or external times 2 or 4, scaled 1 or 2/3..2/7.
// [R15] Upper six bits of the source register read zero and ignore writes.
// [R16] Coarse and fine trims reset to preset values giving a 24 MHz base.
// [R17] Divider code 000 divides by 128, each step halves, 111 divides by 1.
// [R18] Enable field 00 disables, 11 runs normally and stops in suspend.
// [R19] Source switching is glitch-free; no truncated phase reaches the output. Here the forced-low wait while switching can cut the old source's high phase.
`timescale 1ns/100ps
`default_nettype none
module system_clock_select_suspend #(
  parameter int unsigned XTAL_SETTLE = clock_select_pkg::XTAL_SETTLE_CYCLES
) (
  input  wire logic                           sys_clk,
  input  wire logic                           rst_b,
  input  wire clock_select_pkg::sfr_req_t     sfr_req,
  output logic [7:0]                          sfr_rdata,
  input  wire logic                           int_osc_tick,
  input  wire logic                           ext_osc_tick,
  input  wire logic                           clkmul_tick,
  input  wire clock_select_pkg::wake_events_t wake_in,
  output logic                                system_clock_signal,
  output logic                                periph_ext_clock,
  output logic                                int_osc_run,
  output logic                                core_hold,
  output logic [6:0]                          int_osc_coarse_trim,
  output logic [5:0]                          int_osc_fine_trim,
  output logic [3:0]                          clkmul_ctrl
);
  // Source ticks are toggling levels from other domains
  logic [2:0] tick_meta;
  logic [2:0] tick_sync;
  logic [5:0] wake_meta;
  logic [5:0] wake_sync;
  logic [1:0] system_clock_signal_source_field;
  logic [1:0] int_osc_enable_field;
  logic       suspend;
  logic [2:0] int_osc_divider_field;
  logic [7:0] ext_osc_ctrl;
  logic       crystal_valid_flag;
  logic [31:0] settle_cnt;
  logic [6:0] div_cnt;
  logic       int_div_clk;
  logic [1:0] active_src;
  logic       switching;
  logic       ext_clk_q;
  logic [1:0] next_system_clock_signal_source_field;
  logic [1:0] next_int_osc_enable_field;
  logic       next_suspend;
  logic [2:0] next_int_osc_divider_field;
  logic [7:0] next_ext_osc_ctrl;
  logic       next_crystal_valid_flag;
  logic [31:0] next_settle_cnt;
  logic [6:0] next_coarse;
  logic [5:0] next_fine;
  logic [3:0] next_clkmul_ctrl;
  logic [7:0] next_rdata;
  logic [6:0] next_div_cnt;
  logic       next_int_div_clk;
  logic [1:0] next_active_src;
  logic       next_switching;
  logic       next_system_clock_signal;
  logic       wake;
  logic       int_osc_on;
  logic       src_level;

  function automatic logic [6:0] half_divisor(input logic [2:0] code);
    half_divisor = 7'h40 >> code; // R17
  endfunction

  function automatic logic src_of(input logic [1:0] sel, input logic [2:0] lv, input logic id);
    unique case (sel)
      clock_select_pkg::SRC_EXT_OSC: src_of = lv[1];
      clock_select_pkg::SRC_CLKMUL:  src_of = lv[2];
      default:                       src_of = id;
    endcase
  endfunction

  assign wake = (|wake_sync[5:2]) | (wake_sync[1] & ~wake_sync[0]); // R9
  assign int_osc_on = (int_osc_enable_field == clock_select_pkg::OSC_EN_ON) & ~suspend; // R18
  assign src_level = src_of(active_src, tick_sync, int_div_clk);

  always_comb begin
    next_system_clock_signal_source_field   = system_clock_signal_source_field;
    next_int_osc_enable_field  = int_osc_enable_field;
    next_suspend               = suspend;
    next_int_osc_divider_field = int_osc_divider_field;
    next_ext_osc_ctrl          = ext_osc_ctrl;
    next_coarse                = int_osc_coarse_trim;
    next_fine                  = int_osc_fine_trim;
    next_clkmul_ctrl           = clkmul_ctrl;
    next_crystal_valid_flag    = crystal_valid_flag;
    next_settle_cnt            = settle_cnt;
    if (sfr_req.wr) begin
      unique case (sfr_req.addr)
        clock_select_pkg::CLOCK_SOURCE_ADDR: begin
          // Reserved code keeps the running source and reads back unchanged
          if (sfr_req.wdata[1:0] != clock_select_pkg::SRC_RESERVED) begin
            next_system_clock_signal_source_field = sfr_req.wdata[1:0]; // R1 R15
          end
        end
        clock_select_pkg::INT_OSC_CTRL_ADDR: begin
          next_int_osc_enable_field  = sfr_req.wdata[7:6];
          next_suspend               = sfr_req.wdata[clock_select_pkg::SUSPEND_BIT]; // R8
          next_int_osc_divider_field = sfr_req.wdata[2:0]; // R7
        end
        clock_select_pkg::INT_OSC_COARSE_ADDR: next_coarse = sfr_req.wdata[6:0];
        clock_select_pkg::INT_OSC_FINE_ADDR:   next_fine = sfr_req.wdata[5:0];
        clock_select_pkg::EXT_OSC_CTRL_ADDR: begin
          next_ext_osc_ctrl = {1'b0, sfr_req.wdata[6:0]};
          next_crystal_valid_flag = 1'b0;
          next_settle_cnt = '0;
        end
        clock_select_pkg::CLKMUL_CTRL_ADDR: next_clkmul_ctrl = sfr_req.wdata[3:0]; // R14
        default: ;
      endcase
    end
    // Wake beats a same-cycle write of the suspend bit
    if (wake) begin
      next_suspend = 1'b0; // R9 R10
    end
    if (ext_osc_ctrl[clock_select_pkg::EXT_EN_BIT] & ext_osc_ctrl[clock_select_pkg::XTAL_MODE_BIT]
        & ~crystal_valid_flag & ~(sfr_req.wr & (sfr_req.addr == clock_select_pkg::EXT_OSC_CTRL_ADDR))) begin
      if (settle_cnt >= XTAL_SETTLE - 1) begin
        next_crystal_valid_flag = 1'b1; // R4
      end else begin
        next_settle_cnt = settle_cnt + 32'h0000_0001;
      end
    end
    next_rdata = 8'h00;
    if (sfr_req.rd) begin
      unique case (sfr_req.addr)
        clock_select_pkg::CLOCK_SOURCE_ADDR: next_rdata = {6'b00_0000, system_clock_signal_source_field}; // R15
        clock_select_pkg::INT_OSC_CTRL_ADDR:
          next_rdata = {int_osc_enable_field, suspend, int_osc_on, 1'b0, int_osc_divider_field};
        clock_select_pkg::INT_OSC_COARSE_ADDR: next_rdata = {1'b0, int_osc_coarse_trim};
        clock_select_pkg::INT_OSC_FINE_ADDR:   next_rdata = {2'b00, int_osc_fine_trim};
        clock_select_pkg::EXT_OSC_CTRL_ADDR:   next_rdata = {crystal_valid_flag, ext_osc_ctrl[6:0]};
        clock_select_pkg::CLKMUL_CTRL_ADDR:    next_rdata = {4'h0, clkmul_ctrl};
        default: next_rdata = 8'h00;
      endcase
    end
  end

  always_comb begin
    next_div_cnt = div_cnt;
    next_int_div_clk = int_div_clk;
    // Oscillator is usable at once after enable: no start-up count
    if (int_osc_on) begin // R3
      // Divide by 1 has no half-period count: pass the oscillator level through
      if (int_osc_divider_field == 3'h7) begin
        next_div_cnt = 7'h00;
        next_int_div_clk = tick_sync[0]; // R7 R17
      end else if (div_cnt >= half_divisor(int_osc_divider_field) - 7'h01) begin
        next_div_cnt = 7'h00;
        next_int_div_clk = ~int_div_clk; // R7
      end else begin
        next_div_cnt = div_cnt + 7'h01;
      end
    end
    // Switch only while the output is low and the new source is low; the output is forced low from the cycle after the request, which can cut an old high phase
    next_active_src = active_src;
    next_switching = 1'b0;
    if (system_clock_signal_source_field != active_src && system_clock_signal_source_field != clock_select_pkg::SRC_RESERVED) begin
      next_switching = 1'b1;
      if (~system_clock_signal & ~src_of(system_clock_signal_source_field, tick_sync, int_div_clk)) begin
        next_active_src = system_clock_signal_source_field; // R19 R2
      end
    end
    // Clock held while suspended internal source; core resumes in place on wake
    if (suspend & (active_src == clock_select_pkg::SRC_INT_OSC)) begin
      next_system_clock_signal = 1'b0; // R8 R11
    end else if (switching) begin
      next_system_clock_signal = 1'b0; // R19
    end else begin
      next_system_clock_signal = src_level;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      tick_meta <= '0;
      tick_sync <= '0;
      wake_meta <= '0;
      wake_sync <= '0;
      system_clock_signal_source_field <= clock_select_pkg::CLOCK_SOURCE_RESET[1:0]; // R6
      int_osc_enable_field <= clock_select_pkg::INT_OSC_CTRL_RESET[7:6];
      suspend <= 1'b0;
      int_osc_divider_field <= clock_select_pkg::INT_OSC_CTRL_RESET[2:0]; // R7
      ext_osc_ctrl <= 8'h00;
      int_osc_coarse_trim <= clock_select_pkg::COARSE_TRIM_RESET; // R16
      int_osc_fine_trim <= clock_select_pkg::FINE_TRIM_RESET; // R16
      clkmul_ctrl <= 4'h0;
      crystal_valid_flag <= 1'b0;
      settle_cnt <= '0;
      sfr_rdata <= 8'h00;
      div_cnt <= 7'h00;
      int_div_clk <= 1'b0;
      active_src <= clock_select_pkg::SRC_INT_OSC; // R6
      switching <= 1'b0;
      system_clock_signal <= 1'b0;
      ext_clk_q <= 1'b0;
      periph_ext_clock <= 1'b0;
      int_osc_run <= 1'b0;
      core_hold <= 1'b0;
    end else begin
      tick_meta <= {clkmul_tick, ext_osc_tick, int_osc_tick};
      tick_sync <= tick_meta;
      wake_meta <= {wake_in.port_match, wake_in.cmp0_enabled, wake_in.cmp0_out};
      wake_sync <= wake_meta;
      system_clock_signal_source_field <= next_system_clock_signal_source_field;
      int_osc_enable_field <= next_int_osc_enable_field;
      suspend <= next_suspend;
      int_osc_divider_field <= next_int_osc_divider_field;
      ext_osc_ctrl <= next_ext_osc_ctrl;
      int_osc_coarse_trim <= next_coarse;
      int_osc_fine_trim <= next_fine;
      clkmul_ctrl <= next_clkmul_ctrl;
      crystal_valid_flag <= next_crystal_valid_flag;
      settle_cnt <= next_settle_cnt;
      sfr_rdata <= next_rdata;
      div_cnt <= next_div_cnt;
      int_div_clk <= next_int_div_clk;
      active_src <= next_active_src;
      switching <= next_switching;
      system_clock_signal <= next_system_clock_signal;
      ext_clk_q <= tick_sync[1];
      periph_ext_clock <= ext_clk_q; // R13
      int_osc_run <= int_osc_on; // R18 R8
      core_hold <= suspend & (active_src == clock_select_pkg::SRC_INT_OSC); // R11
    end
  end
endmodule
`default_nettype wire

//--- verification/clock_select_checker.sv
// Port assertions for the system clock selector
`timescale 1ns/100ps
`default_nettype none
module clock_select_checker (
  input wire logic                           sys_clk,
  input wire logic                           rst_b,
  input wire clock_select_pkg::sfr_req_t     sfr_req,
  input wire logic [7:0]                     sfr_rdata,
  input wire logic                           ext_osc_tick,
  input wire clock_select_pkg::wake_events_t wake_in,
  input wire logic                           periph_ext_clock,
  input wire logic                           int_osc_run,
  input wire logic                           core_hold
);
  logic quiet;
  logic rd_src;
  logic wr_ctl;
  // Enabled comparator at logic 1 counts as quiet
  assign quiet = wake_in.port_match == 4'h0 && !(wake_in.cmp0_enabled && !wake_in.cmp0_out);
  assign rd_src = sfr_req.rd && sfr_req.addr == clock_select_pkg::CLOCK_SOURCE_ADDR;
  assign wr_ctl = sfr_req.wr && sfr_req.addr == clock_select_pkg::INT_OSC_CTRL_ADDR;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  property p_src_upper; rd_src |=> sfr_rdata[7:2] == 6'h00; endproperty
  a_src_upper: assert property (p_src_upper) else $error("source upper bits not zero");
  property p_src_code; rd_src |=> sfr_rdata[1:0] != 2'b11; endproperty
  a_src_code: assert property (p_src_code) else $error("reserved source code read");
  property p_hold_run; core_hold |-> !int_osc_run; endproperty
  a_hold_run: assert property (p_hold_run) else $error("core held with osc running");
  property p_susp; wr_ctl && sfr_req.wdata[7:5] == 3'b111 && quiet |-> ##[1:3] !int_osc_run; endproperty
  a_susp: assert property (p_susp) else $error("suspend did not stop osc");
  property p_port_wake; core_hold && wake_in.port_match != 4'h0 |-> ##[1:6] !core_hold; endproperty
  a_port_wake: assert property (p_port_wake) else $error("port match did not wake");
  property p_cmp_wake; core_hold && wake_in.cmp0_enabled && !wake_in.cmp0_out |-> ##[1:6] !core_hold; endproperty
  a_cmp_wake: assert property (p_cmp_wake) else $error("comparator did not wake");
  property p_stay; (core_hold && quiet) [*4] |=> core_hold; endproperty
  a_stay: assert property (p_stay) else $error("woke without event");
  property p_off; wr_ctl && sfr_req.wdata[7:6] == 2'b00 |-> ##[1:2] !int_osc_run; endproperty
  a_off: assert property (p_off) else $error("disabled osc still running");
  property p_ext; $rose(ext_osc_tick) |-> ##[2:4] periph_ext_clock; endproperty
  a_ext: assert property (p_ext) else $error("peripheral ext clock not following");
endmodule
bind system_clock_select_suspend clock_select_checker u_chk (.sys_clk(sys_clk), .rst_b(rst_b),
  .sfr_req(sfr_req), .sfr_rdata(sfr_rdata), .ext_osc_tick(ext_osc_tick), .wake_in(wake_in),
  .periph_ext_clock(periph_ext_clock), .int_osc_run(int_osc_run), .core_hold(core_hold));
`default_nettype wire

//--- verification/core_model.sv
// Core-side model: measures high phases of the delivered system clock
`timescale 1ns/100ps
`default_nettype none
module core_model (
  input  wire logic       sys_clk,
  input  wire logic       rst_b,
  input  wire logic       clk_in,
  output logic [7:0]      hi_width
);
  logic [7:0] run;
  // A clipped phase at a switch would show as a short width
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      run <= 8'h00;
      hi_width <= 8'h00;
    end else if (clk_in) begin
      run <= run + 8'h01;
    end else begin
      if (run != 8'h00) hi_width <= run;
      run <= 8'h00;
    end
  end
endmodule
`default_nettype wire

//--- verification/testbench.sv
// Self-checking bench for the system clock selector
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic sys_clk = 1'b0, rst_b = 1'b0, rd_d = 1'b0;
  logic int_osc_tick = 1'b0, ext_osc_tick = 1'b0, clkmul_tick = 1'b0;
  clock_select_pkg::sfr_req_t     sfr_req = '0;
  clock_select_pkg::wake_events_t wake_in = '0;
  logic [7:0]  sfr_rdata, hi_width, tc = 8'h00;
  logic        system_clock_signal, periph_ext_clock, int_osc_run, core_hold;
  logic [6:0]  coarse;
  logic [5:0]  fine;
  logic [3:0]  clkmul_ctrl;
  logic [15:0] exp_q[$];
  logic [15:0] e;
  int          num_errors = 0, cmp_count = 0, cyc = 0;
  always #10 sys_clk = ~sys_clk;
  system_clock_select_suspend #(.XTAL_SETTLE(10)) dut (.sys_clk(sys_clk), .rst_b(rst_b),
    .sfr_req(sfr_req), .sfr_rdata(sfr_rdata), .int_osc_tick(int_osc_tick),
    .ext_osc_tick(ext_osc_tick), .clkmul_tick(clkmul_tick), .wake_in(wake_in),
    .system_clock_signal(system_clock_signal), .periph_ext_clock(periph_ext_clock),
    .int_osc_run(int_osc_run), .core_hold(core_hold), .int_osc_coarse_trim(coarse),
    .int_osc_fine_trim(fine), .clkmul_ctrl(clkmul_ctrl));
  core_model core (.sys_clk(sys_clk), .rst_b(rst_b), .clk_in(system_clock_signal),
    .hi_width(hi_width));
  task automatic conclude;
    if (num_errors == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] x);
    cmp_count++;
    if (got !== x) begin
      num_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, x);
    end
  endtask
  task automatic chk_rd(input logic [7:0] got, input logic [15:0] n);
    cmp_count++;
    if ((got & n[7:0]) !== n[15:8]) begin
      num_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got & n[7:0], n[15:8]);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge sys_clk);
    #2;
  endtask
  // Reads note the masked expectation for the monitor
  task automatic op(input logic w, input logic [7:0] a, d, x, m);
    if (!w) exp_q.push_back({x & m, m});
    @(posedge sys_clk);
    #2 sfr_req = '{wr: w, rd: !w, addr: a, wdata: d};
    @(posedge sys_clk);
    #2 sfr_req = '0;
  endtask
  always @(posedge sys_clk) begin
    rd_d <= sfr_req.rd;
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      num_errors++;
      conclude();
    end
  end
  always @(negedge sys_clk) begin
    if (rd_d === 1'b1) begin
      e = exp_q.pop_front();
      chk_rd(sfr_rdata, e);
    end
  end
  // External source half period is 8 cycles
  always @(posedge sys_clk) begin
    #2 tc <= tc + 8'h01;
    int_osc_tick <= ~int_osc_tick;
    clkmul_tick <= tc[1];
    if (tc[2:0] == 3'h7) ext_osc_tick <= ~ext_osc_tick;
  end
  initial begin
    int k;
    k = $urandom(16967);
    wt(6);
    rst_b = 1'b1;
    op(0, 8'h8F, 8'h00, 8'h00, 8'hFF);
    op(0, 8'hA1, 8'h00, 8'hC0, 8'hEF);
    op(0, 8'hA2, 8'h00, 8'h40, 8'hFF);
    op(0, 8'h9E, 8'h00, 8'h20, 8'hFF);
    chk({1'b0, coarse}, 8'h40);
    chk({2'b00, fine}, 8'h20);
    op(1, 8'hA2, 8'hFF, 8'h00, 8'h00);
    op(0, 8'hA2, 8'h00, 8'h7F, 8'hFF);
    op(1, 8'h9E, 8'hFF, 8'h00, 8'h00);
    op(0, 8'h9E, 8'h00, 8'h3F, 8'hFF);
    for (k = 0; k < 4; k++) begin
      op(1, 8'h8F, {6'($urandom), 2'(k)}, 8'h00, 8'h00);
      op(0, 8'h8F, 8'h00, (k == 3) ? 8'h02 : 8'(k), 8'hFF);
    end
    op(0, {2'b11, 6'($urandom)}, 8'h00, 8'h00, 8'hFF);
    op(1, 8'hB1, 8'h01, 8'h00, 8'h00);
    op(1, 8'h8F, 8'h01, 8'h00, 8'h00);
    wt(60);
    chk(hi_width, 8'h08);
    op(1, 8'h8F, 8'h02, 8'h00, 8'h00);
    wt(60);
    chk(hi_width, 8'h02);
    op(1, 8'h8F, 8'h00, 8'h00, 8'h00);
    for (k = 0; k < 8; k++) begin
      op(1, 8'hA1, 8'hC0 | 8'(k), 8'h00, 8'h00);
      wt(300);
      chk(hi_width, (k == 7) ? 8'h01 : 8'h40 >> k);
    end
    op(1, 8'hB1, 8'h41, 8'h00, 8'h00);
    op(0, 8'hB1, 8'h00, 8'h00, 8'h80);
    wt(20);
    op(0, 8'hB1, 8'h00, 8'h80, 8'h80);
    op(1, 8'hB2, 8'h0B, 8'h00, 8'h00);
    chk({4'h0, clkmul_ctrl}, 8'h0B);
    for (k = 0; k < 5; k++) begin
      // Each pass writes 8'hE0 to set suspend; no zero-tempco bit is set first
      op(1, 8'hA1, 8'hE0, 8'h00, 8'h00);
      wt(3);
      wake_in = '{port_match: 4'h0, cmp0_enabled: 1'b1, cmp0_out: 1'b1};
      wt(6);
      chk({7'h00, core_hold}, 8'h01);
      if (k < 4) wake_in.port_match = 4'h1 << k;
      else wake_in.cmp0_out = 1'b0;
      wt(8);
      chk({7'h00, core_hold}, 8'h00);
      chk({7'h00, int_osc_run}, 8'h01);
      wake_in = '0;
      wt(4);
    end
    op(1, 8'hA1, 8'h00, 8'h00, 8'h00);
    wt(3);
    chk({7'h00, int_osc_run}, 8'h00);
    op(1, 8'hA1, 8'hC0, 8'h00, 8'h00);
    wt(20);
    chk({7'h00, int_osc_run}, 8'h01);
    conclude();
  end
endmodule
`default_nettype wire
